/* hcd_pkg.sv */
// Shared constants and types of the host command decoder: command and
// status identifiers, packet sizes, crash-dump field codes and carriers.
// Assumes a byte-wide command stream and a byte-wide status stream.
package hcd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Command identifiers
	localparam logic [15:0] CMD_POST_MORTEM = 16'h0001;
	localparam logic [15:0] CMD_FW_UPLOAD   = 16'h0002;
	localparam logic [15:0] CMD_RAM_BOOT    = 16'h0003;
	localparam logic [15:0] CMD_FW_FIRST    = 16'h0007; // Injection mode
	localparam logic [15:0] CMD_SELF_TEST   = 16'h000B;
	localparam logic [15:0] CMD_FOC         = 16'h000C;
	localparam logic [15:0] CMD_DUT_CONT    = 16'h0011;
	localparam logic [15:0] CMD_DUT_START   = 16'h0012;
	localparam logic [15:0] CMD_FW_LAST     = 16'h0012;
	localparam logic [15:0] CMD_FIFO_FMT    = 16'h0015;
	localparam logic [15:0] CMD_SPEED_RAISE = 16'h0017;
	localparam logic [15:0] PARAM_WR_FIRST  = 16'h0100;
	localparam logic [15:0] PARAM_WR_LAST   = 16'h0FFF;
	localparam logic [15:0] PARAM_RD_FIRST  = 16'h1000;
	localparam logic [15:0] PARAM_RD_LAST   = 16'h1FFF;

	////////////////////////////////////////////////////////////////////////
	// Command framing
	localparam logic [1:0]  HDR_LAST_BYTE   = 2'h3;     // Id and length
	localparam logic [15:0] SPEED_LEN_FIELD = 16'h0002; // Fixed prefix
	localparam logic [31:0] SPEED_TAIL      = 32'h0000_0080; // LSB first
	localparam logic [17:0] SPEED_TAIL_LEN  = 18'h00004;

	////////////////////////////////////////////////////////////////////////
	// Status packets
	localparam logic [15:0] STAT_CRASH_DUMP = 16'h0003;
	localparam logic [15:0] STAT_SPEED      = 16'h000F;
	localparam logic [15:0] STAT_CMD_ERROR  = 16'h000D;
	localparam logic [15:0] SMALL_LEN       = 16'h0004;
	localparam logic [15:0] CRASH_LEN       = 16'h00C9; // Bytes after 0x03
	localparam logic [7:0]  ERR_COMMAND     = 8'hC0;
	localparam logic [7:0]  SMALL_LAST_IDX  = 8'h07;
	localparam logic [7:0]  CRASH_LAST_IDX  = 8'hCC;
	localparam int          CRASH_BYTES     = 205;
	localparam int          RSVD_BYTES      = 21;       // 0xB8 to 0xCC

	////////////////////////////////////////////////////////////////////////
	// Crash-dump codes
	localparam logic [7:0]  RST_REASON_POR  = 8'h00;
	localparam logic [7:0]  RST_REASON_EXT  = 8'h01;
	localparam logic [7:0]  RST_REASON_HOST = 8'h02;
	localparam logic [7:0]  RST_REASON_WDOG = 8'h04;
	localparam logic [7:0]  ERR_REP_NONE    = 8'h00;
	localparam logic [7:0]  ERR_REP_WDOG    = 8'h19;
	localparam logic [7:0]  ERR_REP_FATAL   = 8'h1B;
	localparam logic [7:0]  ERR_REP_UNHAND  = 8'h44;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [3:0] {
		HND_NONE, HND_CRASH, HND_SPEED, HND_FW_UPLOAD, HND_RAM_BOOT,
		HND_PARAM_WRITE, HND_PARAM_READ, HND_DEVICE_TEST, HND_FOC,
		HND_SELF_TEST, HND_FRAMEWORK
	} hcd_handler_t;

	typedef enum logic [2:0] {
		PK_CRASH = 3'b001,
		PK_SPEED = 3'b010,
		PK_ERROR = 3'b100
	} hcd_pkt_t;

	typedef enum logic [2:0] {
		ST_HDR  = 3'b001,
		ST_PAY  = 3'b010,
		ST_SEND = 3'b100
	} hcd_state_t;

	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} hcd_stat_byte_t;

	typedef struct packed {
		logic         valid;
		hcd_handler_t handler;
		logic [15:0]  cmd_id;
		logic [15:0]  length;
	} hcd_dispatch_t;

	typedef struct packed {
		logic [31:0][31:0] context_words; // Word 0 is core register 0
		logic        crash_valid;
		logic        intctl_valid;
		logic        stack_valid;
		logic        stack_included;
		logic        no_autoexec;
		logic [15:0] stack_size;
		logic [31:0] stack_start;
		logic [31:0] exception_return_address;
		logic [31:0] exception_branch_target;
		logic [31:0] exception_saved_status;
		logic [31:0] exception_cause_word;
		logic [31:0] exception_fault_address;
		logic [3:0]  power_state_field;
		logic        rom_write_err;
		logic        iccm_rsvd_err;
		logic        dccm_rsvd_err;
		logic        reset_por;
		logic        reset_ext;
		logic        reset_host;
		logic        reset_wdog;
		logic [31:0] interrupt_cause;
		logic [7:0]  debug_value;
		logic [7:0]  debug_state;
		logic [7:0]  error_value;
		logic [7:0]  error_aux;
		logic [7:0]  host_int_ctrl;
		logic [7:0]  host_reset_count;
		logic        cause_wdog;
		logic        cause_fatal;
		logic        cause_unhandled;
		logic [31:0] protection_unit_cause;
		logic [31:0] user_stack_pointer;
	} hcd_crash_info_t;

endpackage : hcd_pkg

/* hcd_skid_buf.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on the same clock; outputs come from flip-flops.
`timescale 1ns/1ps
module hcd_skid_buf #(
	parameter int WIDTH = 9                        // Word width
) (
	input  wire logic             ref_clk_i,       // System clock
	input  wire logic             reset_n_i,       // Sync reset, low
	input  wire logic             in_valid_i,      // Word offered
	input  wire logic [WIDTH-1:0] in_data_i,       // Offered word
	output logic                  in_ready_o,      // Room for a word
	output logic                  out_valid_o,     // Word held
	output logic      [WIDTH-1:0] out_data_o,      // Held word
	input  wire logic             out_ready_i      // Drain takes word
);
	logic             skid_valid;
	logic [WIDTH-1:0] skid_data;

	// Handshake terms
	wire push      = in_valid_i & in_ready_o;
	wire out_free  = ~out_valid_o | out_ready_i;
	wire next_skid = skid_valid ? ~out_free : (push & ~out_free);

	// Ready follows the skid slot so a stalled drain never loses a word
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			out_valid_o <= 1'b0;
			skid_valid  <= 1'b0;
			in_ready_o  <= 1'b0;
		end else begin
			if (out_free)
				out_valid_o <= skid_valid | push;
			skid_valid <= next_skid;
			in_ready_o <= ~next_skid;
		end
	end

	// Data path, no reset needed
	always_ff @(posedge ref_clk_i) begin
		if (out_free)
			out_data_o <= skid_valid ? skid_data : in_data_i;
		if (push & ~out_free & ~skid_valid)
			skid_data <= in_data_i;
	end
endmodule : hcd_skid_buf

/* hcd_crash_builder.sv */
// Crash-dump image: lays the saved context into the status packet and
// picks one byte by index. Purely combinational.
// Assumes the crash record inputs are stable while a dump is sent.
`timescale 1ns/1ps
module hcd_crash_builder (
	input  hcd_pkg::hcd_crash_info_t crash_i,  // Saved crash record
	input  wire logic [7:0]          idx_i,    // Packet byte index
	output logic      [7:0]          byte_o    // Packet byte
);
	import hcd_pkg::*;

	logic [8*CRASH_BYTES-1:0] image;
	logic [31:0]              diag_word;
	logic [2:0]               reset_src;
	logic [7:0]               reset_reason;
	logic [7:0]               err_report;

	// Reset-source field is zero after a power-on reset
	assign reset_src = crash_i.reset_por ? 3'h0 :
		{crash_i.reset_wdog, crash_i.reset_host, crash_i.reset_ext};
	assign diag_word = {21'h000000, reset_src, 1'b0,
		crash_i.dccm_rsvd_err, crash_i.iccm_rsvd_err,
		crash_i.rom_write_err, crash_i.power_state_field};

	// Power-on wins when several sources are flagged together, then watchdog, host, external
	assign reset_reason = crash_i.reset_por  ? RST_REASON_POR  :
		crash_i.reset_wdog ? RST_REASON_WDOG :
		crash_i.reset_host ? RST_REASON_HOST :
		crash_i.reset_ext  ? RST_REASON_EXT  : RST_REASON_POR;
	assign err_report = crash_i.cause_wdog      ? ERR_REP_WDOG  :
		crash_i.cause_fatal     ? ERR_REP_FATAL  :
		crash_i.cause_unhandled ? ERR_REP_UNHAND : ERR_REP_NONE;

	// Lowest byte sits on the right, so every field goes out LSB first
	assign image = {{RSVD_BYTES{8'h00}},
		crash_i.user_stack_pointer, crash_i.protection_unit_cause,
		err_report, crash_i.host_reset_count, reset_reason,
		crash_i.host_int_ctrl, crash_i.error_aux, crash_i.error_value,
		crash_i.debug_state, crash_i.debug_value,
		crash_i.interrupt_cause, diag_word,
		crash_i.exception_fault_address, crash_i.exception_cause_word,
		crash_i.exception_saved_status, crash_i.exception_branch_target,
		crash_i.exception_return_address,
		crash_i.stack_start, crash_i.stack_size,
		{4'h0, crash_i.no_autoexec, crash_i.stack_included,
		 crash_i.stack_valid, crash_i.intctl_valid},
		{7'h00, crash_i.crash_valid},
		crash_i.context_words,
		CRASH_LEN, STAT_CRASH_DUMP};

	// Byte pick, index kept in range by the sender
	assign byte_o = image[{idx_i, 3'b000} +: 8];
endmodule : hcd_crash_builder

/* hcd_top.sv */
// Host command decoder: takes command bytes from the host interface,
// checks each command against the running mode, routes accepted ones to
// their handlers and answers locally with crash-dump, speed-raise and
// command-error status packets.
// Assumes the command stream comes from logic on the same clock and that
// handlers consume forwarded payload bytes without back-pressure.
//
// Summary of operation
// - Boot-only commands refused under the framework
// - 0x0100-0x0FFF routed as parameter writes
// - 0x1000-0x1FFF routed as parameter reads
// - Test start and continue routed to test
// - Offset compensation and self-test routed
// - Malformed or invalid commands get error packet
// - Post-mortem command carries zero length field
// - Post-mortem command returns the crash dump
// - Dump starts with code then byte count
// - Saved processor context fills bytes 0x04-0x83
// - Byte 0x84 flags crash information present
// - Byte 0x85 carries four dump flags
// - Stack size and start follow the flags
// - Exception registers, diagnostic, interrupt cause follow
// - Five host register copies at 0xA8-0xAC
// - Byte 0xAD encodes the reset cause
// - Byte 0xAF reports the error cause
// - Protection cause, user stack, reserved tail
// - Reset-source field cleared after power-on
// - Diagnostic word power state and access flags
`timescale 1ns/1ps
module hcd_top (
	input  wire logic                     ref_clk_i,           // 100 MHz clock
	input  wire logic                     reset_n_i,           // Sync reset, low
	input  wire logic                     bootloader_active_i, // Boot mode
	input  wire logic                     cmd_valid_i,         // Command byte
	input  wire logic [7:0]               cmd_data_i,          // Byte value
	output logic                          cmd_ready_o,         // Byte taken
	input  hcd_pkg::hcd_crash_info_t      crash_i,             // Crash record
	output logic                          stat_valid_o,        // Status byte
	output hcd_pkg::hcd_stat_byte_t       stat_o,              // Byte, last
	input  wire logic                     stat_ready_i,        // Host reads
	output hcd_pkg::hcd_dispatch_t        disp_o,              // Route pulse
	output logic                          pay_valid_o,         // Payload byte
	output logic [7:0]                    pay_data_o,          // Payload value
	output logic                          turbo_req_o          // Speed raised
);
	import hcd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Classification of an identifier in the current mode
	function automatic hcd_handler_t classify(input logic [15:0] id,
	                                          input logic        boot);
		hcd_handler_t h;
		h = HND_NONE;
		if (boot) begin
			// Bootloader set only
			case (id)
				CMD_POST_MORTEM: h = HND_CRASH;
				CMD_FW_UPLOAD:   h = HND_FW_UPLOAD;
				CMD_RAM_BOOT:    h = HND_RAM_BOOT;
				CMD_SPEED_RAISE: h = HND_SPEED;
				default:         h = HND_NONE;
			endcase
		end else if (id >= PARAM_WR_FIRST && id <= PARAM_WR_LAST) begin
			h = HND_PARAM_WRITE;
		end else if (id >= PARAM_RD_FIRST && id <= PARAM_RD_LAST) begin
			h = HND_PARAM_READ;
		end else if (id == CMD_DUT_CONT || id == CMD_DUT_START) begin
			h = HND_DEVICE_TEST;
		end else if (id == CMD_FOC) begin
			h = HND_FOC;
		end else if (id == CMD_SELF_TEST) begin
			h = HND_SELF_TEST;
		end else if ((id >= CMD_FW_FIRST && id <= CMD_FW_LAST) ||
		             id == CMD_FIFO_FMT) begin
			h = HND_FRAMEWORK;
		end
		return h;
	endfunction : classify

	// Handlers outside this block receive the command
	function automatic logic routed(input hcd_handler_t h);
		return h != HND_NONE && h != HND_CRASH && h != HND_SPEED;
	endfunction : routed

	////////////////////////////////////////////////////////////////////////
	// State
	hcd_state_t   state;
	hcd_state_t   next_state;
	logic [23:0]  hdr;          // First three header bytes
	logic [1:0]   hdr_cnt;
	logic [15:0]  cmd_id;
	hcd_handler_t hnd;
	logic [17:0]  pay_left;
	logic         bad;          // Command found malformed so far
	logic         fwd;          // Payload goes to a handler
	hcd_pkt_t     pkt;
	logic [7:0]   idx;

	// Buffer links
	logic           buf_ready;
	hcd_stat_byte_t buf_in;
	logic [7:0]     crash_byte;

	////////////////////////////////////////////////////////////////////////
	// Header decode
	logic         take;
	logic         hdr_done;
	logic [15:0]  new_id;
	logic [15:0]  new_len;
	hcd_handler_t new_hnd;
	logic [17:0]  new_pay;
	logic         len_bad;

	assign take     = cmd_valid_i & cmd_ready_o;
	assign hdr_done = take & (state == ST_HDR) & (hdr_cnt == HDR_LAST_BYTE);
	assign new_id   = hdr[15:0];
	assign new_len  = {cmd_data_i, hdr[23:16]};
	assign new_hnd  = classify(new_id, bootloader_active_i);

	// Upload length counts words; the speed command has a fixed tail
	assign new_pay = (new_hnd == HND_FW_UPLOAD) ? {new_len, 2'b00} :
	                 (new_hnd == HND_SPEED)     ? SPEED_TAIL_LEN :
	                 {2'b00, new_len};

	// Zero-length and fixed-prefix checks
	assign len_bad = ((new_hnd == HND_CRASH) & (new_len != 16'h0000)) |
	                 ((new_hnd == HND_RAM_BOOT) & (new_len != 16'h0000)) |
	                 ((new_hnd == HND_SPEED) & (new_len != SPEED_LEN_FIELD));

	////////////////////////////////////////////////////////////////////////
	// Payload tracking and speed tail check
	logic        pay_last;
	logic [1:0]  tail_sel;
	logic        tail_mis;

	assign pay_last = take & (state == ST_PAY) & (pay_left == 18'h00001);
	assign tail_sel = 2'(3'h4 - pay_left[2:0]);
	assign tail_mis = take & (state == ST_PAY) & (hnd == HND_SPEED) &
	                  (cmd_data_i != SPEED_TAIL[{tail_sel, 3'b000} +: 8]);

	////////////////////////////////////////////////////////////////////////
	// Command completion and the answer it needs
	logic         finish;
	logic         fin_bad;
	hcd_handler_t fin_hnd;
	logic         need_resp;
	hcd_pkt_t     fin_pkt;

	assign finish  = (hdr_done & (new_pay == 18'h00000)) | pay_last;
	assign fin_bad = hdr_done ? ((new_hnd == HND_NONE) | len_bad)
	                          : (bad | tail_mis);
	assign fin_hnd = hdr_done ? new_hnd : hnd;

	// Errors take priority over any normal answer
	assign need_resp = fin_bad | (fin_hnd == HND_CRASH) | (fin_hnd == HND_SPEED);
	assign fin_pkt   = fin_bad                ? PK_ERROR :
	                   (fin_hnd == HND_CRASH) ? PK_CRASH :
	                                            PK_SPEED;

	////////////////////////////////////////////////////////////////////////
	// Status packet byte generation
	logic       push;
	logic       push_last;
	logic [7:0] small_byte;
	logic [7:0] last_idx;
	logic [15:0] small_code;

	assign push       = (state == ST_SEND) & buf_ready;
	assign last_idx   = (pkt == PK_CRASH) ? CRASH_LAST_IDX : SMALL_LAST_IDX;
	assign push_last  = push & (idx == last_idx);
	assign small_code = (pkt == PK_SPEED) ? STAT_SPEED : STAT_CMD_ERROR;

	// Short packet: code, length, echoed command, status, all LSB first
	always_comb begin
		case (idx[2:0])
			3'h0:    small_byte = small_code[7:0];
			3'h1:    small_byte = small_code[15:8];
			3'h2:    small_byte = SMALL_LEN[7:0];
			3'h3:    small_byte = SMALL_LEN[15:8];
			3'h4:    small_byte = cmd_id[7:0];
			3'h5:    small_byte = cmd_id[15:8];
			3'h6:    small_byte = (pkt == PK_ERROR) ? ERR_COMMAND : 8'h00;
			default: small_byte = 8'h00;
		endcase
	end

	assign buf_in.data = (pkt == PK_CRASH) ? crash_byte : small_byte;
	assign buf_in.last = (idx == last_idx);

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		case (state)
			ST_HDR: begin
				if (finish & need_resp)
					next_state = ST_SEND;
				else if (hdr_done & ~finish)
					next_state = ST_PAY;
				else
					next_state = ST_HDR;
			end
			ST_PAY: begin
				if (pay_last)
					next_state = need_resp ? ST_SEND : ST_HDR;
				else
					next_state = ST_PAY;
			end
			ST_SEND:  next_state = push_last ? ST_HDR : ST_SEND;
			default:  next_state = ST_HDR;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			state       <= ST_HDR;
			cmd_ready_o <= 1'b0;
			hdr_cnt     <= 2'h0;
			bad         <= 1'b0;
			fwd         <= 1'b0;
			hnd         <= HND_NONE;
			pkt         <= PK_ERROR;
			idx         <= 8'h00;
			pay_left    <= 18'h00000;
			turbo_req_o <= 1'b0;
		end else begin
			state       <= next_state;
			// Commands stall while a status packet is being queued
			cmd_ready_o <= (next_state != ST_SEND);
			if (take & (state == ST_HDR))
				hdr_cnt <= hdr_cnt + 2'h1;
			if (hdr_done) begin
				hnd      <= new_hnd;
				bad      <= (new_hnd == HND_NONE) | len_bad;
				fwd      <= routed(new_hnd) & ~len_bad;
				pay_left <= new_pay;
			end else if (take & (state == ST_PAY)) begin
				pay_left <= pay_left - 18'h00001;
				bad      <= bad | tail_mis;
			end
			if (finish)
				pkt <= fin_pkt;
			idx <= push_last ? 8'h00 : (push ? idx + 8'h01 : idx);
			// Long Run mode returns only through a reset
			if (finish & ~fin_bad & (fin_hnd == HND_SPEED))
				turbo_req_o <= 1'b1;
		end
	end

	// Header bytes and echoed identifier
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			hdr    <= 24'h000000;
			cmd_id <= 16'h0000;
		end else begin
			if (take & (state == ST_HDR))
				hdr <= {cmd_data_i, hdr[23:8]};
			if (hdr_done)
				cmd_id <= new_id;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Routing pulse and forwarded payload
	always_ff @(posedge ref_clk_i) begin
		if (!reset_n_i) begin
			disp_o      <= '0;
			pay_valid_o <= 1'b0;
			pay_data_o  <= 8'h00;
		end else begin
			disp_o.valid   <= hdr_done & routed(new_hnd) & ~len_bad;
			disp_o.handler <= new_hnd;
			disp_o.cmd_id  <= new_id;
			disp_o.length  <= new_len;
			pay_valid_o    <= take & (state == ST_PAY) & fwd;
			pay_data_o     <= cmd_data_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Crash image and status buffer
	hcd_crash_builder u_crash (
		.crash_i (crash_i),
		.idx_i   (idx),
		.byte_o  (crash_byte)
	);

	// Two entries keep a host stall from dropping a byte
	hcd_skid_buf #(
		.WIDTH ($bits(hcd_stat_byte_t))
	) u_buf (
		.ref_clk_i   (ref_clk_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (state == ST_SEND),
		.in_data_i   (buf_in),
		.in_ready_o  (buf_ready),
		.out_valid_o (stat_valid_o),
		.out_data_o  (stat_o),
		.out_ready_i (stat_ready_i)
	);
endmodule : hcd_top

/* hcd_top_properties.sv */
// Port checker for hcd_top: reset, handshakes and routing.
// Assumes it is bound to hcd_top and sees only its ports.
`timescale 1ns/1ps
module hcd_top_properties
	import hcd_pkg::*;
(
	input  wire logic       ref_clk_i,           // Clock
	input  wire logic       reset_n_i,           // Reset, low
	input  wire logic       bootloader_active_i, // Boot mode
	input  wire logic       cmd_valid_i,         // Offer
	input  wire logic [7:0] cmd_data_i,          // Byte
	input  wire logic       cmd_ready_o,         // Take
	input  wire logic       stat_valid_o,        // Status
	input  hcd_stat_byte_t  stat_o,              // Byte, last
	input  wire logic       stat_ready_i,        // Read
	input  hcd_dispatch_t   disp_o,              // Route
	input  wire logic       pay_valid_o,         // Payload
	input  wire logic [7:0] pay_data_o,          // Value
	input  wire logic       turbo_req_o          // Speed
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////////////////
	// Routing follows identifier and mode
	property p_boot_only;
		disp_o.valid && disp_o.handler inside {HND_FW_UPLOAD, HND_RAM_BOOT} |-> $past(bootloader_active_i);
	endproperty
	a_boot_only: assert property (p_boot_only) else $error("boot command routed in framework");
	property p_param_wr;
		disp_o.valid && disp_o.handler == HND_PARAM_WRITE |-> disp_o.cmd_id inside {[16'h0100:16'h0FFF]};
	endproperty
	a_param_wr: assert property (p_param_wr) else $error("parameter write id out of range");
	property p_param_rd;
		disp_o.valid && disp_o.handler == HND_PARAM_READ |-> disp_o.cmd_id inside {[16'h1000:16'h1FFF]};
	endproperty
	a_param_rd: assert property (p_param_rd) else $error("parameter read id out of range");
	property p_dev_test;
		disp_o.valid && disp_o.handler == HND_DEVICE_TEST |-> disp_o.cmd_id inside {16'h0011, 16'h0012};
	endproperty
	a_dev_test: assert property (p_dev_test) else $error("test route with wrong id");
	property p_foc;
		disp_o.valid |-> (disp_o.handler == HND_FOC) == (disp_o.cmd_id == 16'h000C);
	endproperty
	a_foc: assert property (p_foc) else $error("offset compensation route mismatch");
	property p_local;
		disp_o.valid |-> !(disp_o.handler inside {HND_CRASH, HND_SPEED}) ##1 !disp_o.valid;
	endproperty
	a_local: assert property (p_local) else $error("local command routed or long pulse");
	////////////////////////////////////////////////////////////////////////
	// Handshakes and sticky speed flag
	property p_turbo;
		turbo_req_o |=> turbo_req_o;
	endproperty
	a_turbo: assert property (p_turbo) else $error("speed flag dropped");
	property p_pay;
		pay_valid_o |-> $past(cmd_valid_i && cmd_ready_o) && pay_data_o == $past(cmd_data_i);
	endproperty
	a_pay: assert property (p_pay) else $error("payload byte without take");
	property p_hold;
		stat_valid_o && !stat_ready_i |=> stat_valid_o && $stable(stat_o);
	endproperty
	a_hold: assert property (p_hold) else $error("status byte not held");
	property p_ready_up;
		!$past(reset_n_i) |-> !cmd_ready_o ##1 cmd_ready_o;
	endproperty
	a_ready_up: assert property (p_ready_up) else $error("ready late after reset");
endmodule : hcd_top_properties
bind hcd_top hcd_top_properties chk (.ref_clk_i, .reset_n_i, .bootloader_active_i,
	.cmd_valid_i, .cmd_data_i, .cmd_ready_o, .stat_valid_o, .stat_o, .stat_ready_i,
	.disp_o, .pay_valid_o, .pay_data_o, .turbo_req_o);

/* hcd_host_model.sv */
// Host model: offers command bytes and reads status packets.
// Assumes callers start each task just after a rising edge.
`timescale 1ns/1ps
module hcd_host_model
	import hcd_pkg::*;
(
	input  wire logic      ref_clk_i,    // Clock
	input  wire logic      stall_i,      // Slow reader
	input  wire logic      cmd_ready_i,  // Byte taken
	output logic           cmd_valid_o,  // Byte offered
	output logic     [7:0] cmd_data_o,   // Byte value
	input  wire logic      stat_valid_i, // Status byte
	input  hcd_stat_byte_t stat_i,       // Byte, last
	output logic           stat_ready_o  // Reading
);
	int timeouts = 0; // Bytes the block never took
	initial begin
		cmd_valid_o = 1'b0;
		cmd_data_o = 8'h00;
		stat_ready_o = 1'b0;
	end
	// Byte held until ready is seen before the taking edge
	task automatic send(input logic [7:0] b[$]);
		int n;
		foreach (b[i]) begin
			cmd_valid_o = 1'b1;
			cmd_data_o = b[i];
			for (n = 0; cmd_ready_i !== 1'b1 && n < 500; n++)
				@(posedge ref_clk_i) #1;
			if (n == 500) timeouts++;
			@(posedge ref_clk_i) #1;
		end
		cmd_valid_o = 1'b0;
		cmd_data_o = ~cmd_data_o; // Released bus shows no stale byte
	endtask : send
	// Slow host takes every other cycle to exercise the buffer
	task automatic recv(output logic [7:0] p[$], output bit ok);
		int n;
		p = {};
		ok = 1'b0;
		for (n = 0; n < 2000 && !ok; n++) begin
			stat_ready_o = !stall_i || n[0];
			if (stat_valid_i === 1'b1 && stat_ready_o) begin
				p.push_back(stat_i.data);
				ok = stat_i.last === 1'b1;
			end
			@(posedge ref_clk_i) #1;
		end
		stat_ready_o = 1'b0;
	endtask : recv
endmodule : hcd_host_model

/* hcd_top_tb.sv */
// Self-checking bench for hcd_top driven by the host model.
// Assumes hcd_pkg, the checker and the host model compile first.
`timescale 1ns/1ps
module hcd_top_tb;
	import hcd_pkg::*;
	logic            ref_clk_i = 1'b0;
	logic            reset_n_i = 1'b0;
	logic            boot = 1'b1;
	logic            stall = 1'b0;
	logic            cv, cr, sv, sr, pv, turbo;
	logic      [7:0] cd, pd, pay_seen;
	hcd_stat_byte_t  st;
	hcd_dispatch_t   disp, seen = '0;
	hcd_crash_info_t crash = '0;
	int              fails = 0;
	int              check_count = 0;
	logic      [7:0] pkt[$];
	bit              ok;
	always #5 ref_clk_i = ~ref_clk_i;
	// Latch one-cycle pulses for later judgement
	always @(posedge ref_clk_i) begin
		if (disp.valid === 1'b1) seen <= disp;
		if (pv === 1'b1) pay_seen <= pd;
	end
	hcd_top uut (.ref_clk_i, .reset_n_i, .bootloader_active_i(boot), .cmd_valid_i(cv),
		.cmd_data_i(cd), .cmd_ready_o(cr), .crash_i(crash), .stat_valid_o(sv), .stat_o(st),
		.stat_ready_i(sr), .disp_o(disp), .pay_valid_o(pv), .pay_data_o(pd), .turbo_req_o(turbo));
	hcd_host_model host (.ref_clk_i, .stall_i(stall), .cmd_ready_i(cr), .cmd_valid_o(cv),
		.cmd_data_o(cd), .stat_valid_i(sv), .stat_i(st), .stat_ready_o(sr));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic chk_pkt(input logic [7:0] exp[$]);
		host.recv(pkt, ok);
		chk(ok, 1, "packet end");
		chk(pkt.size(), exp.size(), "packet size");
		foreach (exp[i]) chk(pkt[i], exp[i], "packet byte");
	endtask : chk_pkt
	task automatic bad_cmd(input logic [15:0] id, len);
		logic [7:0] q[$];
		q = {id[7:0], id[15:8], len[7:0], len[15:8]};
		repeat (len) q.push_back(8'h5A);
		host.send(q);
		chk_pkt({8'h0D, 8'h00, 8'h04, 8'h00, id[7:0], id[15:8], 8'hC0, 8'h00});
	endtask : bad_cmd
	////////////////////////////////////////////////////////////////////////
	task automatic s_speed;
		host.send({8'h03, 8'h00, 8'h00, 8'h00});
		@(posedge ref_clk_i) #1;
		chk(seen.handler, HND_RAM_BOOT, "boot route");
		host.send({8'h17, 8'h00, 8'h02, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00});
		chk_pkt({8'h0F, 8'h00, 8'h04, 8'h00, 8'h17, 8'h00, 8'h00, 8'h00});
		chk(turbo, 1, "speed flag");
	endtask : s_speed
	// Boot-only, reserved and malformed commands
	task automatic s_refused;
		bad_cmd(CMD_POST_MORTEM, 16'h0001);
		bad_cmd(16'h0100, 16'h0000);
		boot = 1'b0;
		for (int i = 1; i < 4; i++) bad_cmd(16'(i), 16'h0000);
		bad_cmd(16'h0004, 16'h0002);
		bad_cmd(16'h2000, 16'h0000);
	endtask : s_refused
	task automatic s_route;
		logic [15:0] ids[8] = '{16'h0100, 16'h0FFF, 16'h1000, 16'h1FFF,
			16'h0011, 16'h0012, 16'h000B, 16'h000C};
		hcd_handler_t hx[8] = '{HND_PARAM_WRITE, HND_PARAM_WRITE, HND_PARAM_READ,
			HND_PARAM_READ, HND_DEVICE_TEST, HND_DEVICE_TEST, HND_SELF_TEST, HND_FOC};
		foreach (ids[i]) begin
			host.send({ids[i][7:0], ids[i][15:8], 8'h01, 8'h00, 8'(8'hA0 + i)});
			repeat (2) @(posedge ref_clk_i) #1;
			chk(seen.handler, hx[i], "handler");
			chk(seen.length, 16'h0001, "routed length");
			chk(seen.cmd_id, ids[i], "routed id");
			chk(pay_seen, 8'hA0 + i, "payload");
		end
	endtask : s_route
	task automatic s_crash;
		logic [7:0] ix[12] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h84, 8'h85,
			8'h86, 8'h87, 8'hA0, 8'hA1, 8'hAD, 8'hAF};
		logic [7:0] ex[12];
		boot = 1'b1;
		stall = 1'b1;
		crash = '0;
		crash.context_words[0] = 32'h1234_5678;
		{crash.crash_valid, crash.intctl_valid, crash.no_autoexec} = 3'h7;
		crash.stack_size = 16'hBEEF;
		{crash.power_state_field, crash.rom_write_err} = 5'h0B;
		{crash.reset_ext, crash.reset_host, crash.reset_wdog} = 3'h7;
		{crash.cause_fatal, crash.cause_unhandled} = 2'h3;
		for (int p = 0; p < 2; p++) begin
			crash.reset_por = p[0];
			ex = '{8'h03, 8'hC9, 8'h78, 8'h12, 8'h01, 8'h09, 8'hEF, 8'hBE, 8'h15,
				p ? 8'h00 : 8'h07, p ? 8'h00 : 8'h04, 8'h1B};
			host.send({8'h01, 8'h00, 8'h00, 8'h00});
			host.recv(pkt, ok);
			chk(ok, 1, "dump end");
			chk(pkt.size(), 205, "dump size");
			foreach (ix[i]) chk(pkt[ix[i]], ex[i], "dump byte");
			chk(pkt[8'hB8], 8'h00, "reserved");
		end
	endtask : s_crash
	task automatic results;
		fails += host.timeouts;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results
	initial begin
		repeat (10) @(posedge ref_clk_i) #1;
		reset_n_i = 1'b1;
		repeat (2) @(posedge ref_clk_i) #1;
		chk(turbo, 0, "speed flag at reset");
		s_speed;
		s_refused;
		s_route;
		s_crash;
		results;
	end
endmodule : hcd_top_tb
